/* File: logic/pcie_events.sv */
`timescale 1ns/1ps
module pcie_events (
  input  wire logic        clk_sys_in,      // System clock
  input  wire logic        rst_n_in,        // Async reset, active low
  input  wire logic        reg_wr_in,       // Register write strobe
  input  wire logic        reg_rd_in,       // Register read strobe
  input  wire logic [7:0]  reg_addr_in,     // Register offset
  input  wire logic [7:0]  reg_wdata_in,    // Write data
  output logic      [7:0]  reg_rdata_out,   // Read data
  input  wire logic [1:0]  card_type_in,    // Inserted card type
  input  wire logic        battery_detect_one_in, // Battery one / status changed pin
  input  wire logic        battery_detect_two_in, // Battery two / audio pin
  input  wire logic        pin_ready_in,    // Ready / interrupt request pin
  input  wire logic        card_detect_one_in, // Card detect one
  input  wire logic        card_detect_two_in, // Card detect two
  input  wire logic        power_request_in,   // Host requested socket power
  output logic [6:0]       multifunction_terminals_out // Interrupt terminals
);
  logic [7:0] flags_r, mask_r, gctrl_r, sevent_r, smask_r, sigctl_r;
  logic [7:0] flags_nxt, sevent_nxt;
  logic       func_req_r;
  logic [15:0] pwr_cnt_r;
  logic       pwr_busy_r, pwr_done_r;
  logic       b1_ch, b2_ch, rdy_ch, st_rise, cd1_ch, cd2_ch, unused_r1, unused_r2, unused_r3;
  logic       cd1_rise_unused, cd2_rise_unused;
  logic       is_mem, is_io, is_cb, func_valid, status_int, func_int;
  logic [7:0] rdata_nxt;

  // ---------------------------------------------------------------
  // Pin interpretation per card type
  // ---------------------------------------------------------------
  assign is_mem = (card_type_in == pcie_pkg::PCIE_CARD_MEM);
  assign is_io  = (card_type_in == pcie_pkg::PCIE_CARD_IO);
  assign is_cb  = (card_type_in == pcie_pkg::PCIE_CARD_CB);

  pcie_edge u_b1  (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .sig_in(battery_detect_one_in),
                   .rise_out(st_rise), .any_out(b1_ch));
  pcie_edge u_b2  (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .sig_in(battery_detect_two_in),
                   .rise_out(unused_r1), .any_out(b2_ch));
  pcie_edge u_rdy (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .sig_in(pin_ready_in),
                   .rise_out(unused_r2), .any_out(rdy_ch));
  pcie_edge u_cd1 (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .sig_in(card_detect_one_in),
                   .rise_out(cd1_rise_unused), .any_out(cd1_ch));
  pcie_edge u_cd2 (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .sig_in(card_detect_two_in),
                   .rise_out(cd2_rise_unused), .any_out(cd2_ch));
  assign unused_r3 = unused_r1 ^ unused_r2 ^ cd1_rise_unused ^ cd2_rise_unused;

  // ---------------------------------------------------------------
  // Power-up sequence timer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pwr_cnt_r  <= 16'h0000;
      pwr_busy_r <= 1'b0;
      pwr_done_r <= 1'b0;
    end
    else
    begin
      pwr_done_r <= 1'b0;
      if (!power_request_in)
      begin
        pwr_busy_r <= 1'b0;
        pwr_cnt_r  <= 16'h0000;
      end
      else if (!pwr_busy_r && pwr_cnt_r == 16'h0000)
      begin
        pwr_busy_r <= 1'b1;
        pwr_cnt_r  <= 16'(pcie_pkg::PWR_SETTLE_CYC);
      end
      else if (pwr_busy_r)
      begin
        // Count parks at one until power drops, so done fires once
        if (pwr_cnt_r == 16'h0001)
        begin
          pwr_busy_r <= 1'b0;
          pwr_done_r <= 1'b1;
        end
        else
        begin
          pwr_cnt_r <= pwr_cnt_r - 16'h0001;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Flag next values; set wins over clear
  // ---------------------------------------------------------------
  always_comb
  begin
    flags_nxt = flags_r;
    if (reg_rd_in && reg_addr_in == pcie_pkg::OFS_STATUS_FLAGS &&
        !gctrl_r[pcie_pkg::BIT_CLR_METHOD])
      flags_nxt = 8'h00;
    else if (reg_wr_in && reg_addr_in == pcie_pkg::OFS_STATUS_FLAGS &&
             gctrl_r[pcie_pkg::BIT_CLR_METHOD])
      flags_nxt = flags_r & ~reg_wdata_in;
    if (is_mem && b1_ch) flags_nxt[pcie_pkg::BIT_BATT_ONE] = 1'b1;
    if (is_mem && b2_ch) flags_nxt[pcie_pkg::BIT_BATT_TWO] = 1'b1;
    if (is_mem && rdy_ch) flags_nxt[pcie_pkg::BIT_READY] = 1'b1;
    if (is_io && st_rise) flags_nxt[pcie_pkg::BIT_IO_STATUS] = 1'b1;
    if ((is_mem || is_io) && pwr_done_r) flags_nxt[pcie_pkg::BIT_PWR_DONE] = 1'b1;
    flags_nxt[7:4] = 4'h0;

    sevent_nxt = sevent_r;
    if (reg_wr_in && reg_addr_in == pcie_pkg::OFS_SOCK_EVENT)
      sevent_nxt = sevent_r & ~reg_wdata_in;
    if (is_cb && st_rise) sevent_nxt[pcie_pkg::BIT_SE_STATUS] = 1'b1;
    if (cd1_ch) sevent_nxt[pcie_pkg::BIT_SE_DET_ONE] = 1'b1;
    if (cd2_ch) sevent_nxt[pcie_pkg::BIT_SE_DET_TWO] = 1'b1;
    if (is_cb && pwr_done_r) sevent_nxt[pcie_pkg::BIT_SE_PWR] = 1'b1;
    sevent_nxt[7:4] = 4'h0;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      flags_r  <= pcie_pkg::RST_BYTE;
      sevent_r <= pcie_pkg::RST_BYTE;
    end
    else
    begin
      flags_r  <= flags_nxt;
      sevent_r <= sevent_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Writable control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mask_r   <= pcie_pkg::RST_BYTE;
      gctrl_r  <= pcie_pkg::RST_BYTE;
      smask_r  <= pcie_pkg::RST_BYTE;
      sigctl_r <= pcie_pkg::RST_BYTE;
    end
    else if (reg_wr_in)
    begin
      if (reg_addr_in == pcie_pkg::OFS_STATUS_MASK)
        mask_r <= {4'h0, reg_wdata_in[3:0]};
      else if (reg_addr_in == pcie_pkg::OFS_GLOBAL_CTRL)
        gctrl_r <= reg_wdata_in;
      else if (reg_addr_in == pcie_pkg::OFS_SOCK_MASK)
        smask_r <= {4'h0, reg_wdata_in[3:0]};
      else if (reg_addr_in == pcie_pkg::OFS_SIGNAL_CTRL)
        sigctl_r <= {5'h00, reg_wdata_in[2:0]};
    end
  end

  // ---------------------------------------------------------------
  // Functional request, status change and terminal drive
  // ---------------------------------------------------------------
  assign func_valid = (is_io || is_cb) && power_request_in;
  assign func_int   = func_valid && !pin_ready_in;
  assign status_int = |(flags_r & mask_r) || |(sevent_r & smask_r);

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      func_req_r <= 1'b0;
      multifunction_terminals_out <= 7'h00;
    end
    else
    begin
      func_req_r <= func_int;
      multifunction_terminals_out <= 7'h00;
      case (sigctl_r[1:0])
        2'h0:    // Parallel PCI line on terminal 0
          multifunction_terminals_out[0] <= status_int || func_req_r;
        2'h1:    // PCI line for status change, IRQ line for functional
        begin
          multifunction_terminals_out[0] <= status_int;
          multifunction_terminals_out[1] <= func_req_r;
        end
        default: // Serialized: status change on PCI line, requests on terminal 6
        begin
          multifunction_terminals_out[0] <= status_int;
          multifunction_terminals_out[6] <= func_req_r;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_comb
  begin
    rdata_nxt = 8'h00;
    if (reg_addr_in == pcie_pkg::OFS_STATUS_FLAGS)      rdata_nxt = flags_r;
    else if (reg_addr_in == pcie_pkg::OFS_STATUS_MASK)  rdata_nxt = mask_r;
    else if (reg_addr_in == pcie_pkg::OFS_GLOBAL_CTRL)  rdata_nxt = gctrl_r;
    else if (reg_addr_in == pcie_pkg::OFS_CARD_INTCTRL) rdata_nxt = {7'h00, func_req_r};
    else if (reg_addr_in == pcie_pkg::OFS_SOCK_EVENT)   rdata_nxt = sevent_r;
    else if (reg_addr_in == pcie_pkg::OFS_SOCK_MASK)    rdata_nxt = smask_r;
    else if (reg_addr_in == pcie_pkg::OFS_SIGNAL_CTRL)  rdata_nxt = {sigctl_r[7:1], sigctl_r[0] ^ (unused_r3 & 1'b0)};
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      reg_rdata_out <= 8'h00;
    else if (reg_rd_in)
      reg_rdata_out <= rdata_nxt;
  end
endmodule // pcie_events

/* File: logic/pcie_pkg.sv */
package pcie_pkg;
  // Register offsets
  localparam logic [7:0] OFS_STATUS_FLAGS = 8'h04;
  localparam logic [7:0] OFS_STATUS_MASK  = 8'h05;
  localparam logic [7:0] OFS_GLOBAL_CTRL  = 8'h1E;
  localparam logic [7:0] OFS_CARD_INTCTRL = 8'h91;
  localparam logic [7:0] OFS_SOCK_EVENT   = 8'hA0;
  localparam logic [7:0] OFS_SOCK_MASK    = 8'hA4;
  localparam logic [7:0] OFS_SIGNAL_CTRL  = 8'hA8;
  // Legacy flag bit positions
  localparam int BIT_BATT_ONE   = 0;
  localparam int BIT_BATT_TWO   = 1;
  localparam int BIT_READY      = 2;
  localparam int BIT_PWR_DONE   = 3;
  localparam int BIT_IO_STATUS  = 0;
  // Socket event bit positions
  localparam int BIT_SE_STATUS  = 0;
  localparam int BIT_SE_DET_ONE = 1;
  localparam int BIT_SE_DET_TWO = 2;
  localparam int BIT_SE_PWR     = 3;
  localparam int BIT_CLR_METHOD = 2;
  localparam int BIT_FUNC_REQ   = 0;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_SCHEME = 2'h0;
  localparam int NUM_TERMINALS  = 7;
  // Power-up settle time and derived count
  localparam int PWR_SETTLE_US  = 1;
  localparam int CLK_MHZ        = 100;
  localparam int PWR_SETTLE_CYC = PWR_SETTLE_US * CLK_MHZ;

  typedef enum logic [1:0] { PCIE_CARD_MEM, PCIE_CARD_IO, PCIE_CARD_CB, PCIE_CARD_NONE } pcie_card_t;
endpackage

/* File: logic/pcie_edge.sv */
`timescale 1ns/1ps
module pcie_edge (
  input  wire logic clk_sys_in,  // System clock
  input  wire logic rst_n_in,    // Async reset, active low
  input  wire logic sig_in,      // Sampled level
  output logic      rise_out,    // One-cycle rise pulse
  output logic      any_out      // One-cycle change pulse
);
  logic last_r;

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      last_r <= 1'b0;
    end
    else
    begin
      last_r <= sig_in;
    end
  end

  assign rise_out = sig_in & ~last_r;
  assign any_out  = sig_in ^ last_r;
endmodule // pcie_edge

/* File: verif/pcie_events_sva.sv */
`timescale 1ns/1ps
module pcie_events_sva (
  input wire logic       clk_sys_in,                 // Clock
  input wire logic       rst_n_in,                   // Reset
  input wire logic       reg_wr_in,                  // Write
  input wire logic       reg_rd_in,                  // Read
  input wire logic [7:0] reg_addr_in,                // Offset
  input wire logic [7:0] reg_wdata_in,               // Wdata
  input wire logic [7:0] reg_rdata_out,              // Rdata
  input wire logic [1:0] card_type_in,               // Card type
  input wire logic       pin_ready_in,               // Ready pin
  input wire logic       card_detect_one_in,         // Detect pin
  input wire logic       power_request_in,           // Power
  input wire logic [6:0] multifunction_terminals_out // Terminals
);
  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  logic func_c;
  assign func_c = card_type_in inside {2'h1, 2'h2} && !pin_ready_in && power_request_in;
  sequence s_rd(logic [7:0] a);
    reg_rd_in && !reg_wr_in && reg_addr_in == a;
  endsequence
  sequence s_det;
    $changed(card_detect_one_in) ##1 !reg_wr_in [*2] ##1 s_rd(8'hA0);
  endsequence
  chk_unmapped_zero: assert property (
    reg_rd_in && !(reg_addr_in inside {8'h04, 8'h05, 8'h1E, 8'h91, 8'hA0, 8'hA4, 8'hA8})
    |=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
  chk_rdata_hold: assert property (
    !reg_rd_in |=> $stable(reg_rdata_out)) else $error("read data moved");
  chk_mask_upper: assert property (
    reg_rd_in && reg_addr_in inside {8'h05, 8'hA4} |=> reg_rdata_out[7:4] == 4'h0)
    else $error("mask upper bits set");
  chk_mask_back: assert property (
    reg_wr_in && reg_addr_in == 8'h05 ##1 !reg_wr_in ##1 s_rd(8'h05)
    |=> reg_rdata_out == ($past(reg_wdata_in, 3) & 8'h0F)) else $error("mask readback");
  chk_func_flag: assert property (
    func_c [*2] ##1 (func_c && reg_rd_in && reg_addr_in == 8'h91) |=> reg_rdata_out[0])
    else $error("functional flag missing");
  chk_mem_no_func: assert property (
    (card_type_in == 2'h0) [*3] ##0 s_rd(8'h91) |=> !reg_rdata_out[0])
    else $error("memory card functional");
  chk_func_term: assert property (
    func_c [*3] |=> multifunction_terminals_out != 7'h00) else $error("request not signalled");
  chk_detect_flag: assert property (
    s_det |=> reg_rdata_out[1]) else $error("detect flag missing");
endmodule // pcie_events_sva

bind pcie_events pcie_events_sva i_sva (.clk_sys_in, .rst_n_in, .reg_wr_in, .reg_rd_in,
  .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .card_type_in, .pin_ready_in,
  .card_detect_one_in, .power_request_in, .multifunction_terminals_out);

/* File: verif/pcie_card_model.sv */
`timescale 1ns/1ps
module pcie_card_model (
  input  wire logic       clk_sys_in, // Clock
  input  wire logic       rst_n_in,   // Reset
  input  wire logic [4:0] toggle_in,  // Pins to flip
  output logic      [4:0] pins_out    // Battery, ready, detect pins
);
  // ------------------------------------------------------------------
  // Card pins flip on command
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
    if (!rst_n_in) pins_out <= 5'h00;
    else pins_out <= pins_out ^ toggle_in;
endmodule // pcie_card_model

/* File: verif/pcie_events_tb_top.sv */
`timescale 1ns/1ps
module pcie_events_tb_top;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic wr = 1'b0, rd = 1'b0, pwr = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v, m;
  logic [1:0] ctype = 2'h3;
  logic [4:0] tg = 5'h00, pins;
  logic [6:0] terms;
  logic [31:0] seed = 32'h5981;
  logic [7:0] regs [7] = '{8'h04, 8'h05, 8'h1E, 8'h91, 8'hA0, 8'hA4, 8'hA8};
  int n_fail = 0, num_checks = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  pcie_card_model i_card (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .toggle_in(tg),
    .pins_out(pins));
  pcie_events i_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .card_type_in(ctype), .battery_detect_one_in(pins[0]), .battery_detect_two_in(pins[1]),
    .pin_ready_in(pins[2]), .card_detect_one_in(pins[3]), .card_detect_two_in(pins[4]),
    .power_request_in(pwr), .multifunction_terminals_out(terms));
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [7:0] exp_mask(input logic [7:0] d);
    return d & 8'h0F;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk_sys_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic tog(input int i);
    @(posedge clk_sys_in);
    tg <= 5'h01 << i;
    @(posedge clk_sys_in);
    tg <= 5'h00;
    repeat (2) @(posedge clk_sys_in);
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    foreach (regs[i])
    begin
      rd_reg(regs[i]);
      chk(v, pcie_pkg::RST_BYTE);
    end
    rd_reg(8'h33);
    chk(v, 8'h00);
    @(posedge clk_sys_in) ctype <= 2'h0;
    seed = xs(seed);
    m = seed[7:0];
    wr_reg(8'h05, m);
    rd_reg(8'h05);
    chk(v, exp_mask(m));
    wr_reg(8'h05, 8'h0F);
    tog(0);
    #25 chk({1'b0, terms}, 8'h01);
    rd_reg(8'h04);
    chk(v & 8'h03, 8'h01);
    rd_reg(8'h04);
    chk(v & 8'h0F, 8'h00);
    #20 chk({1'b0, terms}, 8'h00);
    tog(1);
    rd_reg(8'h04);
    chk(v & 8'h03, 8'h02);
    tog(2);
    rd_reg(8'h04);
    chk(v & 8'h04, 8'h04);
    @(posedge clk_sys_in) pwr <= 1'b1;
    repeat (pcie_pkg::PWR_SETTLE_CYC + 10) @(posedge clk_sys_in);
    rd_reg(8'h04);
    chk(v & 8'h08, 8'h08);
    chk(v & 8'h08, 8'h08);
    wr_reg(8'h1E, 8'h04);
    tog(2);
    rd_reg(8'h04);
    chk(v & 8'h04, 8'h04);
    rd_reg(8'h04);
    chk(v & 8'h04, 8'h04);
    wr_reg(8'h04, 8'h04);
    rd_reg(8'h04);
    chk(v & 8'h04, 8'h00);
    rd_reg(8'h91);
    chk(v & 8'h01, 8'h00);
    @(posedge clk_sys_in) ctype <= 2'h1;
    rd_reg(8'h91);
    rd_reg(8'h91);
    chk(v & 8'h01, 8'h01);
    chk({7'h00, terms != 7'h00}, 8'h01);
    tog(0);
    rd_reg(8'h04);
    chk(v & 8'h01, 8'h00);
    tog(0);
    rd_reg(8'h04);
    chk(v & 8'h01, 8'h01);
    wr_reg(8'h04, 8'h0F);
    wr_reg(8'hA8, 8'h01);
    repeat (2) @(posedge clk_sys_in);
    #1 chk({1'b0, terms}, 8'h02);
    wr_reg(8'hA8, 8'h02);
    repeat (2) @(posedge clk_sys_in);
    #1 chk({1'b0, terms}, 8'h40);
    wr_reg(8'hA8, 8'h00);
    @(posedge clk_sys_in) ctype <= 2'h2;
    repeat (4)
    begin
      seed = xs(seed);
      wr_reg(8'hA0, 8'hFF);
      tog(3 + seed[0]);
      rd_reg(8'hA0);
      chk(v & 8'h06, 8'h02 << seed[0]);
    end
    tog(0);
    rd_reg(8'hA0);
    chk(v & 8'h01, 8'h00);
    tog(0);
    rd_reg(8'hA0);
    chk(v & 8'h01, 8'h01);
    wr_reg(8'hA0, 8'hFF);
    rd_reg(8'hA0);
    chk(v & 8'h0F, 8'h00);
    final_report;
  end
  initial
  begin
    repeat (3000) @(posedge clk_sys_in);
    n_fail++;
    final_report;
  end
endmodule // pcie_events_tb_top
